/* File: design/io_bank_pkg.sv */
// constants, field layouts and carrier types of the multiplexed pin bank
// assumes one 200 MHz clock and a synchronous active-low reset
// Function
// - each port-mode pin's direction comes from its own direction register bit
// - each multiplexed pin chooses port operation or its peripheral function
// - port widths 7,2,10,3,6,16,16,4,2,4,14 bits
// - ports 0,1,3,4,5,9 have a pull-up option register
// - ports 0,1,3 interrupt edges chosen by rising and falling select registers
// - port 9 edge selection covers only its three upper interrupt pins
// - port 7 direction split into low and high registers
// - key inputs on ports 5 and 9 raise key interrupts per key mode
// - debug reset is active low and clears the debug circuit asynchronously
// - system reset overrides every other operation except the debug circuit reset, which only debug reset controls
// - reset also releases any standby state
// - serial clock pins drive or receive the clock in control mode
// - converter trigger on port 0 pin 3 gated by converter mode register 0
// - interrupt pin on port 0 bit 2 starts as port pin, no edge detection
package io_bank_pkg;
    localparam int NPORT = 11;
    localparam int PW = 16;
    localparam int NIRQ = 13;
    // port indices
    localparam int PORT_P0 = 0;
    localparam int PORT_P3 = 2;
    localparam int PORT_P4 = 3;
    localparam int PORT_P5 = 4;
    localparam int PORT_P7 = 5;
    localparam int PORT_P9 = 6;
    localparam int PORT_DL = 10;
    // register groups, byte address bits [8:6]
    localparam logic [2:0] GRP_DATA = 3'h0;
    localparam logic [2:0] GRP_DIR = 3'h1;
    localparam logic [2:0] GRP_FUNC = 3'h2;
    localparam logic [2:0] GRP_PULL = 3'h3;
    localparam logic [2:0] GRP_RISE = 3'h4;
    localparam logic [2:0] GRP_FALL = 3'h5;
    localparam logic [2:0] GRP_MISC = 3'h6;
    // word index within a group, byte address bits [5:2]
    localparam logic [3:0] IDX_P7_HIGH = 4'hB;
    localparam logic [3:0] IDX_KEY_MODE = 4'h0;
    localparam logic [3:0] IDX_CONV_MODE = 4'h1;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h2;
    localparam logic [3:0] IDX_IRQ_EN = 4'h3;
    localparam logic [3:0] IDX_IRQ_CLR = 4'h4;
    localparam int CONV_TRIG_BIT = 0;
    localparam int FLASH_PIN = 5;
    localparam int NMI_PIN = 2;
    localparam int TRIG_PIN = 3;
    // reset values
    localparam logic [15:0] DIR_RESET = 16'hFFFF;
    localparam logic [15:0] CLR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // implemented pins, element 0 is port 0
    localparam logic [NPORT-1:0][15:0] PIN_MASK = {16'h3FFF, 16'h000F,
        16'h0003, 16'h000F, 16'hFFFF, 16'hFFFF, 16'h003F, 16'h0007,
        16'h03FF, 16'h0003, 16'h007F};
    // pins with a peripheral function
    localparam logic [NPORT-1:0][15:0] CTRL_MASK = {16'h0000, 16'h0000,
        16'h0000, 16'h0002, 16'hE3FF, 16'hFFFF, 16'h003F, 16'h0007,
        16'h033F, 16'h0003, 16'h007F};
    localparam logic [NPORT-1:0][15:0] PULL_MASK = {16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h003F, 16'h0007,
        16'h03FF, 16'h0003, 16'h007F};
    localparam logic [NPORT-1:0][15:0] EDGE_MASK = {16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'hE000, 16'h0000, 16'h0000, 16'h0000,
        16'h0202, 16'h0003, 16'h007C};
    // one port's pad drive, oe_n low while driving
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe_n;
    } pin_drive_t;
    // a peripheral's request for one port
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } alt_drive_t;
endpackage

/* File: design/multiplexed_io_port_bank.sv */
// pin bank: port latches, direction, function select, pull-ups,
// interrupt edge detect, key return, debug reset and flash interlock
// assumes pin inputs synchronous to clk and an Avalon-MM master
`timescale 1ns/100ps
module multiplexed_io_port_bank
    import io_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [8:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [NPORT-1:0][15:0] pin_in,
    output pin_drive_t [NPORT-1:0] pin_drv,
    output logic [NPORT-1:0][15:0] pullup_en,
    input wire alt_drive_t [NPORT-1:0] alt_drv,
    output logic [NPORT-1:0][15:0] periph_in,
    input wire logic debug_reset_n,
    output logic debug_ckt_rst_n,
    input wire logic flash_mode_sel_primary,
    output logic flash_mode_sel_secondary,
    output logic converter_ext_trigger,
    output logic standby_wake,
    output logic irq
);
    logic [NPORT-1:0][15:0] lvl;
    logic [NPORT-1:0][15:0] prev;
    logic [7:0] key_return_mode_reg;
    logic [7:0] converter_mode_reg0;
    logic [NIRQ-1:0] irq_status;
    logic [NIRQ-1:0] irq_enable;
    logic [7:0] key_prev;

    wire [NPORT-1:0][15:0] rdv;
    wire [NPORT-1:0][15:0] ev;
    pin_drive_t [NPORT-1:0] next_drv;
    wire [NPORT-1:0][15:0] next_pull;

    // bus decode, a request is served on its second cycle
    wire req = read | write;
    wire acc = req & ~waitrequest;
    wire wr_acc = write & ~waitrequest;
    wire [2:0] grp = address[8:6];
    wire [3:0] idx = address[5:2];
    wire [15:0] wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    wire [7:0] bmask = {8{byteenable[0]}};
    wire misc_wr = wr_acc && grp == GRP_MISC;
    wire p7h_hit = wr_acc && grp == GRP_DIR && idx == IDX_P7_HIGH;

    // key inputs: port 5 bits 5..0 then port 9 bits 1..0
    wire [7:0] keys = {lvl[PORT_P9][1:0], lvl[PORT_P5][5:0]};

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : gen_port
            logic [15:0] latch;
            logic [15:0] dir;
            logic [15:0] pmc;
            logic [15:0] pu;
            logic [15:0] rise;
            logic [15:0] fall;
            wire hit = wr_acc && idx == 4'(p);
            wire is_p7 = (p == PORT_P7);
            wire lo_mask_p7 = is_p7 && hit && grp == GRP_DIR;
            // port 7 direction lives in two byte-wide halves
            wire [15:0] dmask = is_p7 ?
                (lo_mask_p7 ? {8'h00, bmask} :
                 p7h_hit ? {bmask, 8'h00} : 16'h0000) :
                ((hit && grp == GRP_DIR) ? wmask : 16'h0000);
            wire [15:0] dval = p7h_hit ? {writedata[7:0], writedata[7:0]}
                : writedata[15:0];
            wire [15:0] wv = writedata[15:0];
            wire [15:0] pm = PIN_MASK[p];
            wire [15:0] cm = pmc & CTRL_MASK[p];
            // flash interlock keeps the shared DL pin undriven
            wire [15:0] lock = (p == PORT_DL && flash_mode_sel_primary)
                ? 16'h0020 : 16'h0000;

            // configuration registers of this port
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    latch <= CLR_RESET;
                    dir <= DIR_RESET;
                    pmc <= CLR_RESET;
                    pu <= CLR_RESET;
                    rise <= CLR_RESET;
                    fall <= CLR_RESET;
                end else begin
                    dir <= (dir & ~dmask) | (dval & dmask);
                    if (hit && grp == GRP_DATA)
                        latch <= (latch & ~wmask) | (wv & wmask);
                    if (hit && grp == GRP_FUNC)
                        pmc <= (pmc & ~wmask) | (wv & wmask);
                    if (hit && grp == GRP_PULL)
                        pu <= (pu & ~wmask) | (wv & wmask);
                    if (hit && grp == GRP_RISE)
                        rise <= (rise & ~wmask) | (wv & wmask);
                    if (hit && grp == GRP_FALL)
                        fall <= (fall & ~wmask) | (wv & wmask);
                end
            end

            // pad drive: peripheral owns the pin in control mode
            assign next_drv[p].out = pm & ((cm & alt_drv[p].out)
                | (~cm & latch));
            assign next_drv[p].oe_n = ~(pm & ~lock & ((cm & alt_drv[p].oe)
                | (~cm & ~dir)));
            assign next_pull[p] = pu & PULL_MASK[p];
            // edge events only on interrupt pins in control mode input
            assign ev[p] = EDGE_MASK[p] & cm & dir
                & ((rise & lvl[p] & ~prev[p])
                | (fall & ~lvl[p] & prev[p]));
            // read back by group, pins beyond the width read zero
            assign rdv[p] = pm & (
                (grp == GRP_DATA) ? ((dir & lvl[p]) | (~dir & latch)) :
                (grp == GRP_DIR) ? (is_p7 ? {8'h00, dir[7:0]} : dir) :
                (grp == GRP_FUNC) ? (pmc & CTRL_MASK[p]) :
                (grp == GRP_PULL) ? (pu & PULL_MASK[p]) :
                (grp == GRP_RISE) ? (rise & EDGE_MASK[p]) :
                (grp == GRP_FALL) ? (fall & EDGE_MASK[p]) :
                16'h0000);
        end
    endgenerate

    // key pins usable only as control-mode inputs, falling edge
    wire [7:0] key_ok = {gen_port[PORT_P9].pmc[1:0],
        gen_port[PORT_P5].pmc[5:0]} & {gen_port[PORT_P9].dir[1:0],
        gen_port[PORT_P5].dir[5:0]};
    wire key_evt = |(key_return_mode_reg & key_ok & key_prev & ~keys);

    // event layout of the status register
    wire [NIRQ-1:0] evt_vec = {key_evt, ev[PORT_P9][15:13], ev[PORT_P3][9],
        ev[PORT_P3][1], ev[1][1:0], ev[PORT_P0][6:2]};
    wire clr_hit = misc_wr && idx == IDX_IRQ_CLR;
    wire [NIRQ-1:0] clr_vec = clr_hit ? writedata[NIRQ-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [NIRQ-1:0] next_status = (irq_status & ~clr_vec) | evt_vec;

    // read selection
    wire port_ok = idx < 4'(NPORT);
    wire [15:0] p7h_rd = {8'h00, gen_port[PORT_P7].dir[15:8]};
    wire [31:0] misc_rd =
        (idx == IDX_KEY_MODE) ? {24'h0, key_return_mode_reg} :
        (idx == IDX_CONV_MODE) ? {24'h0, converter_mode_reg0} :
        (idx == IDX_IRQ_STAT) ? 32'(irq_status) :
        (idx == IDX_IRQ_EN) ? 32'(irq_enable) : 32'h0;
    wire [31:0] next_rd = (grp == GRP_MISC) ? misc_rd :
        (grp == GRP_DIR && idx == IDX_P7_HIGH) ? {16'h0, p7h_rd} :
        (grp < GRP_MISC && port_ok) ? {16'h0, rdv[idx]} : 32'h0;

    // bus handshake: one wait cycle, data loaded on the same edge as the release
    always_ff @(posedge clk) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else begin
            waitrequest <= ~(req & waitrequest);
            if (read && waitrequest)
                readdata <= next_rd;
        end
    end

    // misc control registers and the sticky status
    always_ff @(posedge clk) begin
        if (!rstn) begin
            key_return_mode_reg <= BYTE_RESET;
            converter_mode_reg0 <= BYTE_RESET;
            irq_enable <= '0;
            irq_status <= '0;
        end else begin
            if (misc_wr && idx == IDX_KEY_MODE && byteenable[0])
                key_return_mode_reg <= writedata[7:0];
            if (misc_wr && idx == IDX_CONV_MODE && byteenable[0])
                converter_mode_reg0 <= writedata[7:0];
            if (misc_wr && idx == IDX_IRQ_EN)
                irq_enable <= writedata[NIRQ-1:0];
            irq_status <= next_status;
        end
    end

    // pin sampling and all pad-facing outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl <= '0;
            prev <= '0;
            key_prev <= 8'h00;
            pin_drv <= {NPORT{{16'h0000, 16'hFFFF}}};
            pullup_en <= '0;
            irq <= 1'b0;
            flash_mode_sel_secondary <= 1'b0;
            converter_ext_trigger <= 1'b0;
            standby_wake <= 1'b1;
        end else begin
            lvl <= pin_in & PIN_MASK;
            prev <= lvl;
            key_prev <= keys;
            pin_drv <= next_drv;
            pullup_en <= next_pull;
            irq <= |(irq_status & irq_enable);
            flash_mode_sel_secondary <= flash_mode_sel_primary
                & lvl[PORT_DL][FLASH_PIN];
            converter_ext_trigger <= converter_mode_reg0[CONV_TRIG_BIT]
                & gen_port[PORT_P0].pmc[TRIG_PIN]
                & lvl[PORT_P0][TRIG_PIN];
            standby_wake <= 1'b0;
        end
    end

    assign periph_in = lvl;

    // debug circuit reset: asserted without a clock, released on one
    always_ff @(posedge clk or negedge debug_reset_n) begin
        if (!debug_reset_n)
            debug_ckt_rst_n <= 1'b0;
        else
            debug_ckt_rst_n <= 1'b1;
    end

    AST_RESET_INPUT: assert property (@(posedge clk)
        $rose(rstn) |-> gen_port[PORT_P4].dir == DIR_RESET
            && pin_drv[PORT_P4].oe_n == 16'hFFFF && pullup_en == '0)
        else $error("pins not input after reset");
    AST_DIR_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        !gen_port[PORT_P4].pmc[0] && !gen_port[PORT_P4].dir[0]
        |=> !pin_drv[PORT_P4].oe_n[0])
        else $error("output pin not driven");
    AST_CTRL_MODE: assert property (@(posedge clk) disable iff (!rstn)
        gen_port[PORT_P3].pmc[0] |=>
        pin_drv[PORT_P3].out[0] == $past(alt_drv[PORT_P3].out[0]))
        else $error("peripheral value not on pin");
    AST_PULLUP: assert property (@(posedge clk) disable iff (!rstn)
        ##1 pullup_en[PORT_P0] ==
            ($past(gen_port[PORT_P0].pu) & PULL_MASK[PORT_P0])
            && pullup_en[PORT_P7] == 16'h0000)
        else $error("pull-up enable wrong");
    AST_EDGE_P0: assert property (@(posedge clk) disable iff (!rstn)
        $rose(lvl[PORT_P0][3]) && gen_port[PORT_P0].rise[3]
        && gen_port[PORT_P0].pmc[3] && gen_port[PORT_P0].dir[3]
        ##1 !clr_hit |-> irq_status[1])
        else $error("rising edge not captured");
    AST_EDGE_P9: assert property (@(posedge clk) disable iff (!rstn)
        $rose(lvl[PORT_P9][13]) && gen_port[PORT_P9].fall[13]
        && !gen_port[PORT_P9].rise[13] && irq_status[9] == 1'b0
        && !clr_hit |=> irq_status[9] == 1'b0)
        else $error("unselected edge captured");
    AST_NMI_OFF: assert property (@(posedge clk) disable iff (!rstn)
        !gen_port[PORT_P0].pmc[NMI_PIN] && !irq_status[0]
        |=> !irq_status[0])
        else $error("edge seen on port-mode pin");
    AST_KEY: assert property (@(posedge clk) disable iff (!rstn)
        $fell(keys[0]) && key_return_mode_reg[0] && key_ok[0]
        |=> irq_status[12])
        else $error("key event lost");
    AST_DBG_RST: assert property (@(posedge clk)
        !debug_reset_n |-> !debug_ckt_rst_n)
        else $error("debug reset not asserted");
    AST_FLASH_LOCK: assert property (@(posedge clk) disable iff (!rstn)
        flash_mode_sel_primary |=> pin_drv[PORT_DL].oe_n[5])
        else $error("flash pin driven");
    AST_TRIGGER: assert property (@(posedge clk) disable iff (!rstn)
        !converter_mode_reg0[CONV_TRIG_BIT] |=>
        !converter_ext_trigger)
        else $error("trigger passed while disabled");
    AST_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        req && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest not one cycle");
endmodule

/* File: bench/pad_board_model.sv */
// board side of the pin bank: resolves every pad level
// assumes the bank and this model share clk; board drive is level based
`timescale 1ns/100ps
module pad_board_model
    import io_bank_pkg::*;
(
    input wire logic clk,
    input wire pin_drive_t [NPORT-1:0] pin_drv,
    input wire logic [NPORT-1:0][15:0] pullup_en,
    input wire logic [NPORT-1:0][15:0] ext_en,
    input wire logic [NPORT-1:0][15:0] ext_val,
    input wire logic flash_mode_sel_primary,
    output logic [NPORT-1:0][15:0] pin_in
);
    logic [NPORT-1:0][15:0] float_q;
    // a pad nobody drives drifts, so show a level that flips each cycle
    always_ff @(posedge clk) begin
        float_q <= ~pin_in;
    end
    // bank drive wins, then the flash lock low on DL pin 5, then the board, then the pull-up
    always_comb begin
        for (int k = 0; k < NPORT; k++) begin
            for (int b = 0; b < 16; b++) begin
                if (pin_drv[k].oe_n[b] == 1'b0) begin
                    pin_in[k][b] = pin_drv[k].out[b];
                end else if (k == PORT_DL && b == FLASH_PIN &&
                    flash_mode_sel_primary) begin
                    pin_in[k][b] = 1'b0;
                end else if (ext_en[k][b]) begin
                    pin_in[k][b] = ext_val[k][b];
                end else if (pullup_en[k][b]) begin
                    pin_in[k][b] = 1'b1;
                end else begin
                    pin_in[k][b] = float_q[k][b];
                end
            end
        end
    end
endmodule

/* File: bench/multiplexed_io_port_bank_bench.sv */
// self-checking bench for the pin bank: bus tasks, pad model, checks
// assumes the bank package and the pad model are compiled first
`timescale 1ns/100ps
module multiplexed_io_port_bank_bench;
    import io_bank_pkg::*;
    logic clk, rstn, read, write, waitrequest, irq, standby_wake;
    logic debug_reset_n, debug_ckt_rst_n, converter_ext_trigger;
    logic flash_mode_sel_primary, flash_mode_sel_secondary;
    logic [8:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata;
    logic [63:0] note;
    logic [63:0] expq[$];
    logic [NPORT-1:0][15:0] pin_in, pullup_en, periph_in, ext_en, ext_val;
    logic [15:0] dv[NPORT];
    logic [15:0] pv[NPORT];
    pin_drive_t [NPORT-1:0] pin_drv;
    alt_drive_t [NPORT-1:0] alt_drv;
    int error_cnt = 0;
    int checked = 0;

    multiplexed_io_port_bank multiplexed_io_port_bank_i (.clk, .rstn,
        .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .pin_in, .pin_drv, .pullup_en, .alt_drv, .periph_in,
        .debug_reset_n, .debug_ckt_rst_n, .flash_mode_sel_primary,
        .flash_mode_sel_secondary, .converter_ext_trigger, .standby_wake,
        .irq);
    pad_board_model pad_board_model_i (.clk, .pin_drv, .pullup_en,
        .ext_en, .ext_val, .flash_mode_sel_primary, .pin_in);

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // one access, held until waitrequest is sampled low; reads note d & m
    task automatic bus(logic wr, logic [8:0] a, logic [31:0] d,
        logic [31:0] m);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        if (!wr) expq.push_back({m, d & m});
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 100) begin
            n++;
            @(posedge clk);
        end
        if (n == 100) chk("waitrequest", 0, 1);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [2:0] g, logic [3:0] i, logic [31:0] d);
        bus(1'b1, {g, i, 2'b00}, d, '0);
    endtask
    task automatic rd(logic [2:0] g, logic [3:0] i, logic [31:0] e,
        logic [31:0] m);
        bus(1'b0, {g, i, 2'b00}, e, m);
    endtask
    // pin events need a few edges to reach status and irq
    task automatic pin(int k, int b, logic v);
        ext_val[k][b] <= v;
        tick(5);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // read data is compared where waitrequest answers
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            note = expq.pop_front();
            chk("readdata", note[31:0], readdata & note[63:32]);
        end
    end
    // cut a hang short
    initial begin
        tick(20000);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hF;
        alt_drv = '0;
        debug_reset_n = 1'b1; // kept released until the debug reset check
        flash_mode_sel_primary = 1'b0;
        ext_en = '1;
        ext_val = '0;
        void'($urandom(37192));
        tick(6);
        chk("standby_wake", 1, standby_wake);
        rstn <= 1'b1;
        tick(2);
        chk("standby_wake", 0, standby_wake);
        for (int k = 0; k < NPORT; k++) begin
            chk("oe_n", PIN_MASK[k], pin_drv[k].oe_n & PIN_MASK[k]);
            chk("pullup", 0, pullup_en[k]);
        end
        rd(GRP_FUNC, 4'h0, 0, 32'hFFFF);
        rd(3'h7, 4'h0, 0, 32'hFFFFFFFF);
        // random latch and direction on every port, port mode only
        for (int k = 0; k < NPORT; k++) begin
            dv[k] = 16'($urandom) & PIN_MASK[k];
            pv[k] = 16'($urandom) & PIN_MASK[k];
            ext_val[k] <= 16'($urandom);
            wr(GRP_DATA, 4'(k), {16'h0000, pv[k]});
            if (k == PORT_P7) begin
                // analog use never enabled, so the reads below are legal
                wr(GRP_DIR, 4'(k), {24'h0, dv[k][7:0]});
                wr(GRP_DIR, IDX_P7_HIGH, {24'h0, dv[k][15:8]});
            end else begin
                wr(GRP_DIR, 4'(k), {16'h0, dv[k]});
            end
            tick(2);
            chk("oe_n", dv[k], pin_drv[k].oe_n & PIN_MASK[k]);
            chk("out", pv[k] & ~dv[k],
                pin_drv[k].out & PIN_MASK[k] & ~dv[k]);
            rd(GRP_DATA, 4'(k), {16'h0, (dv[k] & ext_val[k]) |
                (pv[k] & ~dv[k])}, {16'h0, PIN_MASK[k]});
        end
        for (int k = 0; k < NPORT; k++) begin
            pv[k] = (k == PORT_P0) ? 16'h007F : 16'($urandom);
            wr(GRP_PULL, 4'(k), {16'h0, pv[k]});
        end
        tick(2);
        for (int k = 0; k < NPORT; k++)
            chk("pullup", pv[k] & PULL_MASK[k], pullup_en[k]);
        // board lets go of port 0, pull-ups must hold it high
        wr(GRP_DIR, 4'h0, 32'h7F);
        ext_en[PORT_P0] <= '0;
        tick(2);
        rd(GRP_DATA, 4'h0, 32'h7F, 32'h7F);
        chk("periph_in", 16'h7F, periph_in[PORT_P0] & 16'h7F);
        ext_en[PORT_P0] <= '1;
        ext_val[PORT_P0] <= '0;
        wr(GRP_RISE, 4'h0, 32'h4);
        wr(GRP_MISC, IDX_IRQ_EN, 32'h1FFF);
        pin(PORT_P0, NMI_PIN, 1'b1);
        rd(GRP_MISC, IDX_IRQ_STAT, 0, 32'h1);
        wr(GRP_FUNC, 4'h0, 32'h4);
        pin(PORT_P0, NMI_PIN, 1'b0);
        rd(GRP_MISC, IDX_IRQ_STAT, 0, 32'h1);
        pin(PORT_P0, NMI_PIN, 1'b1);
        rd(GRP_MISC, IDX_IRQ_STAT, 32'h1, 32'h1);
        chk("irq", 1, irq);
        wr(GRP_MISC, IDX_IRQ_CLR, 32'h1FFF);
        tick(3);
        chk("irq", 0, irq);
        // rising select moves to the trigger pin for the edge check below
        wr(GRP_RISE, 4'h0, 32'h8);
        wr(GRP_FALL, 4'h0, 32'h4);
        wr(GRP_MISC, IDX_IRQ_EN, 0);
        pin(PORT_P0, NMI_PIN, 1'b0);
        rd(GRP_MISC, IDX_IRQ_STAT, 32'h1, 32'h1);
        chk("irq", 0, irq);
        wr(GRP_MISC, IDX_IRQ_EN, 32'h1);
        tick(3);
        chk("irq", 1, irq);
        // key 0 on port 5 pin 0, falling edge
        wr(GRP_DIR, 4'(PORT_P5), 32'h3F);
        wr(GRP_MISC, IDX_KEY_MODE, 32'h1);
        wr(GRP_FUNC, 4'(PORT_P5), 32'h1);
        pin(PORT_P5, 0, 1'b1);
        pin(PORT_P5, 0, 1'b0);
        rd(GRP_MISC, IDX_IRQ_STAT, 32'h1000, 32'h1000);
        wr(GRP_MISC, IDX_IRQ_CLR, 32'h1FFF);
        // converter trigger gated by its mode bit
        wr(GRP_MISC, IDX_CONV_MODE, 32'h1);
        wr(GRP_FUNC, 4'h0, 32'hC);
        pin(PORT_P0, TRIG_PIN, 1'b1);
        chk("trigger", 1, converter_ext_trigger);
        rd(GRP_MISC, IDX_IRQ_STAT, 32'h2, 32'h2);
        wr(GRP_MISC, IDX_IRQ_EN, 32'h2);
        wr(GRP_MISC, IDX_CONV_MODE, 0);
        tick(3);
        chk("trigger", 0, converter_ext_trigger);
        // port 9 pin 13 set for falling edges only
        wr(GRP_DIR, 4'(PORT_P9), 32'hFFFF);
        pin(PORT_P9, 13, 1'b0);
        wr(GRP_FALL, 4'(PORT_P9), 32'hE000);
        wr(GRP_FUNC, 4'(PORT_P9), 32'hE000);
        pin(PORT_P9, 13, 1'b1);
        rd(GRP_MISC, IDX_IRQ_STAT, 0, 32'h200);
        pin(PORT_P9, 13, 1'b0);
        rd(GRP_MISC, IDX_IRQ_STAT, 32'h200, 32'h200);
        // serial clock pin: peripheral drives only in control mode
        wr(GRP_DIR, 4'(PORT_P4), 32'h7);
        alt_drv[PORT_P4] <= {16'h0004, 16'h0004};
        wr(GRP_FUNC, 4'(PORT_P4), 0);
        chk("oe_n", 1, pin_drv[PORT_P4].oe_n[2]);
        wr(GRP_FUNC, 4'(PORT_P4), 32'h4);
        tick(2);
        chk("oe_n", 0, pin_drv[PORT_P4].oe_n[2]);
        chk("out", 1, pin_drv[PORT_P4].out[2]);
        alt_drv[PORT_P4] <= '0;
        ext_val[PORT_P4][2] <= 1'b1;
        tick(3);
        chk("oe_n", 1, pin_drv[PORT_P4].oe_n[2]);
        chk("periph_in", 1, periph_in[PORT_P4][2]);
        // flash interlock releases port DL pin 5
        wr(GRP_DIR, 4'(PORT_DL), 0);
        wr(GRP_DATA, 4'(PORT_DL), 32'h20);
        flash_mode_sel_primary <= 1'b1;
        // pin still reads high for two edges while the lock takes hold
        tick(4);
        chk("oe_n", 1, pin_drv[PORT_DL].oe_n[FLASH_PIN]);
        chk("flash_sec", 0, flash_mode_sel_secondary);
        flash_mode_sel_primary <= 1'b0;
        tick(3);
        chk("oe_n", 0, pin_drv[PORT_DL].oe_n[FLASH_PIN]);
        // debug reset acts between clock edges
        debug_reset_n <= 1'b0;
        #1;
        chk("debug_rst", 0, debug_ckt_rst_n);
        @(posedge clk);
        debug_reset_n <= 1'b1;
        tick(2);
        chk("debug_rst", 1, debug_ckt_rst_n);
        // second reset in mid-run with irq pending
        chk("irq", 1, irq);
        rstn <= 1'b0;
        tick(2);
        chk("standby_wake", 1, standby_wake);
        chk("irq", 0, irq);
        chk("oe_n", 16'h7F, pin_drv[PORT_P0].oe_n & 16'h7F);
        rstn <= 1'b1;
        tick(2);
        chk("standby_wake", 0, standby_wake);
        rd(GRP_FUNC, 4'h0, 0, 32'hFFFF);
        tick(2);
        end_of_test();
    end
endmodule
